// file: rtl/adrp_ref_ctrl.sv
/*
  Two-wire target front end and internal reference power sequencing of a
  sampling converter. The bus clock pin clocks a tiny bit-capture stage; all
  decoding runs on ref_clk, which must be much faster than the bus clock.
  The converter result is assumed stable on ref_clk whenever it is read.
*/
// Contract
// R1: Software wanting the internal reference sets the reference power bit in every conversion command.
// R2: After the reference is turned on again the controller waits the full settling time before trusting results; test 2 reads at once.
// R3: An off reference stays off until a command with the reference power bit set is followed by Stop or repeated Start.
// R4: Reference power-up starts at that Stop or repeated Start, not at the command byte.
// R5: Further commands with the bit set while the reference runs just keep it on without restarting it.
// R6: Any command with the reference power bit clear turns the reference off at once.
// R7: With an external reference the controller clears the bit and waits for that reference to settle.
// R8: Turn-on is write address, command with the bit set, Stop, then a wait before normal reads; test 2 turns on with a repeated Start and no wait.
// R9: To chain conversions the controller uses a repeated Start back to write addressing.
// R10: The two power bits select power down, reference off and converter on, reference on only, or both on.
// R11: After reset the reference is off until enabled by command.
// R12: A result is returned as four zero bits and the upper four bits, then the lower eight bits.
// R13: After write addressing, the converter powers and starts at the fourth command bit, and the command is acknowledged.
// R14: The target answers to address 10010 followed by the two address-select inputs.
// R15: There is no ready flag, so the controller times the settling wait itself from its Stop.
module adrp_ref_ctrl (
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic scl,
  // Bus data, open drain
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address straps
  input wire logic address_select_high,
  input wire logic address_select_low,
  // Converter side
  input wire logic [11:0] conv_result,
  output logic conv_start,
  output logic converter_power,
  output logic reference_power,
  output logic single_ended_select,
  output logic [2:0] channel_select
);

  adrp_pkg::adrp_core_s q, d;
  adrp_pkg::adrp_link_s lq, ld;
  logic link_rst_n;
  logic [adrp_pkg::SYNC_W-1:0] sy;
  logic scl_s, sda_s, a1_s, a0_s, lbit_s, ltog_s;
  logic bit_ev, fall_ev, start_ev, stop_ev;
  logic [7:0] rx;

  // Reset brought onto the bus clock; the bus clock must run during reset
  adrp_sync #(.W(1)) u_link_rst (
    .clk(scl),
    .reset_n(1'b1),
    .din(reset_n),
    .dout(link_rst_n)
  );

  // Bit capture on the bus clock rising edge, flagged by a toggle
  always_comb begin
    ld.bit_val = sda_in;
    ld.tog = ~lq.tog;
  end

  always_ff @(posedge scl) begin
    if (!link_rst_n) begin
      lq <= '0;
    end else begin
      lq <= ld;
    end
  end

  // Captured bit stays still for a whole bus period, so the toggle marks it valid
  adrp_sync #(.W(adrp_pkg::SYNC_W)) u_sync (
    .clk(ref_clk),
    .reset_n(reset_n),
    .din({scl, sda_in, address_select_high, address_select_low, lq.bit_val, lq.tog}),
    .dout(sy)
  );

  assign {scl_s, sda_s, a1_s, a0_s, lbit_s, ltog_s} = sy;
  assign bit_ev = ltog_s ^ q.tog_p;
  assign fall_ev = q.scl_p & ~scl_s;
  assign start_ev = scl_s & q.scl_p & q.sda_p & ~sda_s;
  assign stop_ev = scl_s & q.scl_p & ~q.sda_p & sda_s;
  assign rx = {q.sh[6:0], lbit_s};

  always_comb begin
    d = q;
    d.tog_p = ltog_s;
    d.scl_p = scl_s;
    d.sda_p = sda_s;
    d.conv_start = 1'b0;
    d.sda_o = 1'b0;
    if (start_ev || stop_ev) begin
      d.st = start_ev ? adrp_pkg::ST_ADDR : adrp_pkg::ST_IDLE;
      d.cnt = '0;
      d.ack = 1'b0;
      d.sda_oe = 1'b0;
      // Power-up begins only at the bus condition after the enabling command
      if (q.ref_pending) begin
        d.ref_on = 1'b1; // R3 R4
        d.ref_pending = 1'b0;
      end
      // Mode 00 and 10 drop the converter at the Stop that ends the transaction, not at a repeated Start
      if (stop_ev && !q.cmd.converter_power_bit) begin
        d.adc_on = 1'b0; // R10
      end
    end else begin
      unique case (q.st)
        adrp_pkg::ST_IDLE, adrp_pkg::ST_IGNORE: begin
          d.sda_oe = 1'b0;
        end
        adrp_pkg::ST_ADDR: begin
          if (bit_ev) begin
            d.sh = rx;
            d.cnt = q.cnt + 3'h1;
            if (q.cnt == adrp_pkg::CNT_LAST) begin
              d.rw = rx[adrp_pkg::ADDR_RW_POS];
              if (rx[7:1] == {adrp_pkg::ADDR_FIXED, a1_s, a0_s}) begin
                d.st = adrp_pkg::ST_ADDR_ACK; // R14
              end else begin
                d.st = adrp_pkg::ST_IGNORE;
              end
            end
          end
        end
        adrp_pkg::ST_ADDR_ACK: begin
          if (fall_ev) begin
            if (!q.ack) begin
              d.ack = 1'b1;
              d.sda_oe = 1'b1;
            end else begin
              d.ack = 1'b0;
              d.cnt = '0;
              if (q.rw) begin
                // Upper result byte goes first
                d.tx = {adrp_pkg::RESULT_PAD, conv_result[11:8]}; // R12
                d.lo = conv_result[7:0]; // R12
                // First bit on the wire is the top pad bit, not a result bit
                d.sda_oe = ~adrp_pkg::RESULT_PAD[3];
                d.st = adrp_pkg::ST_TX;
              end else begin
                d.sda_oe = 1'b0;
                d.st = adrp_pkg::ST_CMD;
              end
            end
          end
        end
        adrp_pkg::ST_CMD: begin
          if (bit_ev) begin
            d.sh = rx;
            d.cnt = q.cnt + 3'h1;
            if (q.cnt == adrp_pkg::CNT_CONV_START) begin
              d.conv_start = 1'b1; // R13
              d.adc_on = 1'b1; // R13
            end
            if (q.cnt == adrp_pkg::CNT_LAST) begin
              d.cmd.single_ended_select = rx[adrp_pkg::CMD_SD_POS];
              d.cmd.channel_select = rx[adrp_pkg::CMD_CH_HI:adrp_pkg::CMD_CH_LO];
              d.cmd.reference_power_bit = rx[adrp_pkg::CMD_REF_POS];
              d.cmd.converter_power_bit = rx[adrp_pkg::CMD_CONV_POS];
              if (!rx[adrp_pkg::CMD_REF_POS]) begin
                d.ref_on = 1'b0; // R6
                d.ref_pending = 1'b0; // R6
              end else if (!q.ref_on) begin
                d.ref_pending = 1'b1; // R3
              end
              // A running reference is left alone, so no restart of its turn-on
              d.st = adrp_pkg::ST_CMD_ACK; // R5
            end
          end
        end
        adrp_pkg::ST_CMD_ACK: begin
          if (fall_ev) begin
            d.ack = ~q.ack;
            d.sda_oe = ~q.ack; // R13
            if (q.ack) begin
              d.st = adrp_pkg::ST_IGNORE;
            end
          end
        end
        adrp_pkg::ST_TX: begin
          if (bit_ev) begin
            d.cnt = q.cnt + 3'h1;
            if (q.cnt == adrp_pkg::CNT_LAST) begin
              d.st = adrp_pkg::ST_TX_END;
            end
          end else if (fall_ev) begin
            d.tx = {q.tx[6:0], 1'b0};
            d.sda_oe = ~q.tx[6];
          end
        end
        adrp_pkg::ST_TX_END: begin
          if (fall_ev) begin
            d.sda_oe = 1'b0;
            d.st = adrp_pkg::ST_MACK;
          end
        end
        adrp_pkg::ST_MACK: begin
          if (bit_ev) begin
            // Only an acknowledged upper byte earns the lower byte
            d.st = (!lbit_s && !q.ack) ? adrp_pkg::ST_TX_LOAD : adrp_pkg::ST_IGNORE;
          end
        end
        adrp_pkg::ST_TX_LOAD: begin
          if (fall_ev) begin
            d.ack = 1'b1;
            d.cnt = '0;
            d.tx = q.lo;
            d.sda_oe = ~q.lo[7];
            d.st = adrp_pkg::ST_TX;
          end
        end
        default: begin
          d.st = adrp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      q <= '0; // R11
    end else begin
      q <= d;
    end
  end

  assign sda_out = q.sda_o;
  assign sda_oe = q.sda_oe;
  assign conv_start = q.conv_start;
  assign converter_power = q.adc_on; // R10
  assign reference_power = q.ref_on; // R10
  assign single_ended_select = q.cmd.single_ended_select;
  assign channel_select = q.cmd.channel_select;

endmodule

// file: rtl/adrp_sync.sv
/*
  Two-flop synchroniser for a bundle of levels.
  Assumes each bit is a slow level; bits are not kept coherent with each other.
*/
module adrp_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } adrp_sync_s;

  adrp_sync_s q, d;

  always_comb begin
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.s2;

endmodule

// file: shared/adrp_pkg.sv
/*
  Shared constants and types for the converter reference power control.
  Assumes an open-drain two-wire bus resolved outside the design files.
*/
package adrp_pkg;

  // Fixed upper part of the 7-bit target address
  localparam logic [4:0] ADDR_FIXED = 5'h12;
  localparam int unsigned ADDR_RW_POS = 0;

  // Command byte field positions, most significant first on the wire
  localparam int unsigned CMD_SD_POS = 7;
  localparam int unsigned CMD_CH_HI = 6;
  localparam int unsigned CMD_CH_LO = 4;
  localparam int unsigned CMD_REF_POS = 3;
  localparam int unsigned CMD_CONV_POS = 2;

  // Bit counter values and the result pad bits
  localparam logic [2:0] CNT_LAST = 3'h7;
  localparam logic [2:0] CNT_CONV_START = 3'h3;
  localparam logic [3:0] RESULT_PAD = 4'h0;

  // Synchroniser widths
  localparam int unsigned SYNC_W = 6;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_CMD = 4'h3,
    ST_CMD_ACK = 4'h4,
    ST_TX = 4'h5,
    ST_TX_END = 4'h6,
    ST_MACK = 4'h7,
    ST_TX_LOAD = 4'h8,
    ST_IGNORE = 4'h9
  } adrp_state_e;

  // Latched command fields
  typedef struct packed {
    logic single_ended_select;
    logic [2:0] channel_select;
    logic reference_power_bit;
    logic converter_power_bit;
  } adrp_cmd_s;

  // Reference-clock side state
  typedef struct packed {
    adrp_state_e st;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic ack;
    logic [7:0] tx;
    logic [7:0] lo;
    logic tog_p;
    logic scl_p;
    logic sda_p;
    logic sda_oe;
    logic sda_o;
    logic ref_on;
    logic ref_pending;
    logic adc_on;
    logic conv_start;
    adrp_cmd_s cmd;
  } adrp_core_s;

  // Link-clock side state
  typedef struct packed {
    logic bit_val;
    logic tog;
  } adrp_link_s;

endpackage

// file: verification/adrp_bus_ctrl_model.sv
/* Behavioural two-wire bus controller with bit-level tasks.
   Assumes a pull-up resolves the data line outside; the clock stands still between frames. */
module adrp_bus_ctrl_model #(
  parameter int H = 500
) (
  // Bus lines
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'h1;
    sda_pull = 1'h0;
  end
  // Fast clocking with data released, only to clear the bus-clock reset stage
  task automatic tick(input int n);
    repeat (n) begin
      #50 scl = 1'h0;
      #50 scl = 1'h1;
    end
  endtask
  // Start from idle, or repeated Start from clock low
  task automatic start();
    // Step off the system clock edge so no bus change races a sampling edge
    #5;
    sda_pull = 1'h0;
    #H scl = 1'h1;
    #H sda_pull = 1'h1;
    #H scl = 1'h0;
    #H;
  endtask
  task automatic stop();
    sda_pull = 1'h1;
    #H scl = 1'h1;
    #H sda_pull = 1'h0;
    #H;
  endtask
  task automatic bit_x(input logic b, output logic r);
    sda_pull = !b;
    #H scl = 1'h1;
    #(H/2) r = sda;
    #(H/2) scl = 1'h0;
  endtask
  task automatic put(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(v[i], r);
    bit_x(1'h1, ack);
  endtask
  task automatic get(input logic nack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'h1, v[i]);
    bit_x(nack, r);
  endtask
endmodule

// file: verification/adrp_ref_ctrl_monitor.sv
/* Port checker for the reference power control.
   Assumes it is bound to adrp_ref_ctrl and that the bus lines are resolved outside. */
module adrp_ref_ctrl_monitor (
  // Clock, reset and bus
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Converter side
  input wire logic conv_start,
  input wire logic converter_power,
  input wire logic reference_power,
  input wire logic [2:0] channel_select
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Cycles since a Start or Stop edge; legal data never moves while the clock is high
  logic sda_p_q;
  logic [3:0] age_q;
  always_ff @(posedge ref_clk) begin
    sda_p_q <= sda_in;
    if (!reset_n) begin
      age_q <= 4'hf;
    end else if (scl && sda_in != sda_p_q) begin
      age_q <= 4'h0;
    end else if (age_q != 4'hf) begin
      age_q <= age_q + 4'h1;
    end
  end
  a_reset_clears: assert property (disable iff (1'h0) !reset_n |=> !reference_power && !converter_power && !sda_oe)
    else $error("outputs not cleared by reset");
  a_ref_at_stop: assert property ($rose(reference_power) |-> age_q < 4'ha)
    else $error("reference powered away from a Stop or repeated Start");
  a_conv_start_bit: assert property (conv_start |-> scl ##1 (!conv_start && converter_power))
    else $error("conversion start pulse malformed");
  a_conv_off_stop: assert property ($fell(converter_power) |-> age_q < 4'ha)
    else $error("converter power dropped away from a Stop");
  a_ack_clock_low: assert property ($rose(sda_oe) |-> !scl)
    else $error("data line pulled while clock high");
  a_data_held_high: assert property (scl && $past(scl) |-> $stable(sda_oe))
    else $error("data line moved while clock high");
  a_open_drain: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  a_fields_at_byte: assert property ($changed(channel_select) |-> scl)
    else $error("command fields latched off a clock high phase");
endmodule

bind adrp_ref_ctrl adrp_ref_ctrl_monitor u_mon (.ref_clk(ref_clk), .reset_n(reset_n), .scl(scl), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .conv_start(conv_start), .converter_power(converter_power),
  .reference_power(reference_power), .channel_select(channel_select));

// file: verification/adrp_ref_ctrl_tb_top.sv
/* Testbench for the reference power control: command, read and address cases.
   Assumes the bus controller model and the bound port checker. */
module adrp_ref_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk;
  logic reset_n = 1'h0;
  logic address_select_high = 1'h1;
  logic address_select_low = 1'h0;
  logic [11:0] conv_result = 12'h000;
  logic scl, sda_pull, sda_out, sda_oe, conv_start, converter_power, reference_power, single_ended_select;
  logic [2:0] channel_select;
  wire sda = !(sda_pull || (sda_oe && !sda_out));
  int n_fail = 0;
  int check_count = 0;
  // Per test: repeated Start after the command, then the two power bits
  logic [2:0] plan [5] = '{3'h3, 3'h1, 3'h6, 3'h3, 3'h0};
  adrp_bus_ctrl_model ctl (.scl(scl), .sda_pull(sda_pull), .sda(sda));
  adrp_ref_ctrl uut (.ref_clk(ref_clk), .reset_n(reset_n), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .address_select_high(address_select_high), .address_select_low(address_select_low),
    .conv_result(conv_result), .conv_start(conv_start), .converter_power(converter_power),
    .reference_power(reference_power), .single_ended_select(single_ended_select), .channel_select(channel_select));
  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmd_xfer(input logic [1:0] sa, input logic [7:0] c, output logic a0, output logic a1);
    ctl.start();
    ctl.put({adrp_pkg::ADDR_FIXED, sa, 1'h0}, a0);
    ctl.put(c, a1);
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    report_and_stop();
  end
  initial begin
    logic a0, a1, ref_exp;
    logic [7:0] b0, b1, cmd;
    logic [11:0] res;
    ref_exp = 1'h0;
    fork
      ctl.tick(4);
    join_none
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'h1;
    // The bus-clock reset stage only lets go once the bus clock runs after release
    ctl.tick(4);
    repeat (6) @(posedge ref_clk);
    chk(reference_power, 1'h0);
    for (int i = 0; i < 5; i++) begin
      res = 12'hda3 ^ {3{i[3:0]}};
      @(posedge ref_clk);
      conv_result <= res;
      cmd = {i[0], i[2:0], plan[i][1:0], 2'h0};
      cmd_xfer(2'h2, cmd, a0, a1);
      chk(a0, 1'h0);
      chk(a1, 1'h0);
      repeat (10) @(posedge ref_clk);
      chk(reference_power, plan[i][1] & ref_exp);
      chk(converter_power, 1'h1);
      if (!plan[i][2]) begin
        ctl.stop();
        // Settling is timed here because the block gives no ready indication
        repeat (40) @(posedge ref_clk);
      end
      ctl.start();
      ctl.put({adrp_pkg::ADDR_FIXED, 2'h2, 1'h1}, a0);
      ctl.get(1'h0, b0);
      ctl.get(1'h1, b1);
      chk({b0, b1}, {4'h0, res});
      ctl.stop();
      repeat (10) @(posedge ref_clk);
      ref_exp = plan[i][1];
      chk(reference_power, ref_exp);
      chk(converter_power, plan[i][0]);
      chk({single_ended_select, channel_select}, {i[0], i[2:0]});
      $display("test %0d done", i);
    end
    cmd_xfer(2'h1, 8'h8c, a0, a1);
    chk(a0, 1'h1);
    ctl.stop();
    repeat (10) @(posedge ref_clk);
    chk(reference_power, 1'h0);
    $display("test address done");
    report_and_stop();
  end
endmodule
